//--- rtl/uart_frame_defs.svh
// named offsets, field positions, reset values and timing counts of the serial control block
`ifndef UART_FRAME_DEFS_SVH
`define UART_FRAME_DEFS_SVH
`define ADDR_W          12
`define OFS_FORMAT      12'h000
`define OFS_ENABLE      12'h004
`define OFS_DATA        12'h008
`define OFS_STATUS      12'h00C
`define OFS_DIR         12'h010
`define FMT_LOOP        7
`define FMT_WAITSTOP    6
`define FMT_RXSRC       5
`define FMT_NINE        4
`define FMT_WAKE        3
`define FMT_IDLE_TYPE   2
`define FMT_PAR         1
`define FMT_ODD         0
`define EN_TXE_IRQ      7
`define EN_TXDONE_IRQ   6
`define EN_TXON         3
`define EN_RXON         2
`define EN_STANDBY      1
`define ST_TXEMPTY      7
`define ST_TXDONE       6
`define ST_RXFULL       5
`define ST_IDLE         4
`define ST_FRAMERR      1
`define ST_PARERR       0
`define DIR_OUT         0
`define FORMAT_RST      8'h00
`define ENABLE_RST      8'h00
`define DIR_RST         1'b0
`define CLK_PERIOD_NS   10
`define BIT_TIME_NS     160
`define BIT_CYCLES      (`BIT_TIME_NS / `CLK_PERIOD_NS)
`define CNT_W           5
`define IDLE_BITS_8     4'hA
`define IDLE_BITS_9     4'hB
`define LAST_BIT_8      4'h7
`define LAST_BIT_9      4'h8
`endif

//--- rtl/uart_frame_pkg.sv
// state types of the serial control block
package uart_frame_pkg;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
endpackage

//--- rtl/uart_frame_and_loop_control.sv
// serial frame, loop routing and control registers behind an apb slave
//
// Summary of operation
// - loop select 0: separate receive, transmit pins
// - loop select 1: receive pin unused, receiver fed from transmitter or transmit pin
// - wait-stop 0: keep running during cpu wait
// - wait-stop 1: freeze transmitter, receiver and interrupt requests during cpu wait
// - receiver source ignored while loop select 0
// - loop 1, source 0: internal loop-back
// - loop 1, source 1: single wire on transmit pin
// - start, 8 or 9 data lsb first, stop
// - wakeup method: idle line or address mark
// - idle count starts after start or stop bit
// - idle type 1 excludes stop and trailing ones
// - parity on: msb generated on send, checked on receive
// - parity off: all bits are plain data
// - parity type: 0 even, 1 odd, parity included
// - tx empty flag and enable raise interrupt
// - tx done interrupt: enable 0 requests, 1 disables
// - second control register accessible at any time
// - internal loop-back releases transmit pin to port
// - single wire: direction bit steers shared pin
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "uart_frame_defs.svh"
module uart_frame_and_loop_control (
  input  wire logic                 pclk,           // bus clock
  input  wire logic                 presetn,        // async reset, active low
  input  wire logic                 psel,           // apb select
  input  wire logic                 penable,        // apb access phase
  input  wire logic                 pwrite,         // apb direction
  input  wire logic [`ADDR_W-1:0]   paddr,          // apb byte address
  input  wire logic [31:0]          pwdata,         // apb write data
  output logic      [31:0]          prdata,         // apb read data
  output logic                      pready,         // apb ready
  output logic                      pslverr,        // apb error on unmapped address
  input  wire logic                 cpu_wait,       // processor in wait mode
  input  wire logic                 rxd_pin,        // receive pin level
  input  wire logic                 txd_pin_in,     // transmit pin level read back
  output logic                      txd_pin_out,    // transmit pin drive value
  output logic                      txd_pin_oe,     // transmit pin drive enable
  output logic                      txd_pin_owned,  // transmit pin held by this block
  output logic                      tx_empty_irq,   // transmit buffer empty request
  output logic                      tx_done_irq,    // transmission complete request
  output logic                      clocks_frozen   // block frozen by wait mode
);
  import uart_frame_pkg::*;

  localparam logic [`CNT_W-1:0] BIT_LAST  = `CNT_W'(`BIT_CYCLES - 1);     // full bit period
  localparam logic [`CNT_W-1:0] HALF_LAST = `CNT_W'(`BIT_CYCLES / 2 - 1); // mid start bit

  // pin synchronisers
  logic rxd_meta_q, rxd_sync_q;   // receive pin, two stages
  logic txi_meta_q, txi_sync_q;   // transmit pin read back, two stages

  // bus and register state
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d;
  logic        pslverr_q, pslverr_d;
  logic [7:0]  fmt_q, fmt_d;       // format control register
  logic [7:0]  en_q, en_d;         // enable control register
  logic        dir_q, dir_d;       // single wire direction, 1 drives out
  logic [8:0]  txbuf_q, txbuf_d;   // transmit data buffer
  logic [8:0]  rxbuf_q, rxbuf_d;   // received character
  logic        txe_q, txe_d;       // transmit buffer empty flag
  logic        txc_q, txc_d;       // transmission complete flag
  logic        rxf_q, rxf_d;       // receive full flag
  logic        idle_q, idle_d;     // idle line flag
  logic        fe_q, fe_d;         // framing error flag
  logic        perr_q, perr_d;     // parity error flag
  logic        oe_q, oe_d;         // registered pin enable
  logic        own_q, own_d;       // registered pin ownership
  logic        tirq_q, tirq_d;     // registered empty request
  logic        cirq_q, cirq_d;     // registered done request
  logic        frz_q, frz_d;       // registered freeze state

  // transmitter state
  tx_state_t        tx_st_q, tx_st_d;
  logic [`CNT_W-1:0] tx_cnt_q, tx_cnt_d;
  logic [3:0]        tx_bit_q, tx_bit_d;
  logic [8:0]        tx_sh_q, tx_sh_d;
  logic              tx_line_q, tx_line_d;

  // receiver state
  rx_state_t        rx_st_q, rx_st_d;
  logic [`CNT_W-1:0] rx_cnt_q, rx_cnt_d;
  logic [3:0]        rx_bit_q, rx_bit_d;
  logic [8:0]        rx_sh_q, rx_sh_d;
  logic              rx_prev_q, rx_prev_d;
  logic [3:0]        run1_q, run1_d;     // high bit times seen toward idle
  logic              armed_q, armed_d;   // idle may be reported once

  // decoded controls
  logic setup, done, wr, rd, mapped;
  logic hit_fmt, hit_en, hit_data, hit_st, hit_dir;
  logic run, loop, single, internal, nine, tx_on, rx_on;
  logic rx_in, load, frame_end, got_char, idle_hit, wake_clear;
  logic [3:0] last_bit, idle_goal;
  logic [8:0] tx_word, rx_word;
  logic [31:0] rd_value;

  // mode decode and receiver input routing
  always_comb begin
    run      = ~(cpu_wait & fmt_q[`FMT_WAITSTOP]);
    loop     = fmt_q[`FMT_LOOP];
    single   = loop & fmt_q[`FMT_RXSRC];
    internal = loop & ~fmt_q[`FMT_RXSRC];
    nine     = fmt_q[`FMT_NINE];
    tx_on    = en_q[`EN_TXON];
    rx_on    = en_q[`EN_RXON];
    last_bit = nine ? `LAST_BIT_9 : `LAST_BIT_8;
    idle_goal = nine ? `IDLE_BITS_9 : `IDLE_BITS_8;
    if (!loop) begin
      rx_in = rxd_sync_q;
    end else if (internal) begin
      rx_in = tx_line_q;
    end else begin
      rx_in = dir_q ? tx_line_q : txi_sync_q;
    end
  end

  // apb decode and read mux
  always_comb begin
    setup    = psel & ~penable;
    done     = psel & penable & pready_q;
    wr       = done & pwrite;
    rd       = done & ~pwrite;
    hit_fmt  = (paddr == `OFS_FORMAT);
    hit_en   = (paddr == `OFS_ENABLE);
    hit_data = (paddr == `OFS_DATA);
    hit_st   = (paddr == `OFS_STATUS);
    hit_dir  = (paddr == `OFS_DIR);
    mapped   = hit_fmt | hit_en | hit_data | hit_st | hit_dir;
    rd_value = '0;
    if (hit_fmt) begin
      rd_value[7:0] = fmt_q;
    end else if (hit_en) begin
      rd_value[7:0] = en_q;
    end else if (hit_data) begin
      rd_value[8:0] = rxbuf_q;
    end else if (hit_st) begin
      rd_value[`ST_TXEMPTY] = txe_q;
      rd_value[`ST_TXDONE]  = txc_q;
      rd_value[`ST_RXFULL]  = rxf_q;
      rd_value[`ST_IDLE]    = idle_q;
      rd_value[`ST_FRAMERR] = fe_q;
      rd_value[`ST_PARERR]  = perr_q;
    end else if (hit_dir) begin
      rd_value[`DIR_OUT] = dir_q;
    end
    // answer one cycle after setup, data and error captured at setup
    pready_d  = setup;
    pslverr_d = setup & ~mapped;
    prdata_d  = setup ? rd_value : '0;
  end

  // transmit character build with optional parity in the msb
  always_comb begin
    tx_word = nine ? txbuf_q : {1'b0, txbuf_q[7:0]};
    if (fmt_q[`FMT_PAR]) begin
      if (nine) begin
        tx_word[8] = (^txbuf_q[7:0]) ^ fmt_q[`FMT_ODD];
      end else begin
        tx_word[7] = (^txbuf_q[6:0]) ^ fmt_q[`FMT_ODD];
      end
    end
  end

  // transmitter next state
  always_comb begin
    tx_st_d   = tx_st_q;
    tx_cnt_d  = tx_cnt_q;
    tx_bit_d  = tx_bit_q;
    tx_sh_d   = tx_sh_q;
    tx_line_d = tx_line_q;
    load      = 1'b0;
    frame_end = 1'b0;
    if (run) begin
      case (tx_st_q)
        TX_IDLE: begin
          tx_line_d = 1'b1;
          if (tx_on && !txe_q) begin
            // take the buffer, start bit goes out
            load      = 1'b1;
            tx_sh_d   = tx_word;
            tx_st_d   = TX_START;
            tx_cnt_d  = '0;
            tx_line_d = 1'b0;
          end
        end
        TX_START: begin
          tx_cnt_d = tx_cnt_q + 1'b1;
          if (tx_cnt_q == BIT_LAST) begin
            tx_cnt_d  = '0;
            tx_bit_d  = '0;
            tx_line_d = tx_sh_q[0];
            tx_sh_d   = {1'b0, tx_sh_q[8:1]};
            tx_st_d   = TX_DATA;
          end
        end
        TX_DATA: begin
          tx_cnt_d = tx_cnt_q + 1'b1;
          if (tx_cnt_q == BIT_LAST) begin
            tx_cnt_d = '0;
            if (tx_bit_q == last_bit) begin
              tx_line_d = 1'b1;
              tx_st_d   = TX_STOP;
            end else begin
              tx_bit_d  = tx_bit_q + 1'b1;
              tx_line_d = tx_sh_q[0];
              tx_sh_d   = {1'b0, tx_sh_q[8:1]};
            end
          end
        end
        TX_STOP: begin
          tx_cnt_d = tx_cnt_q + 1'b1;
          if (tx_cnt_q == BIT_LAST) begin
            frame_end = 1'b1;
            tx_st_d   = TX_IDLE;
          end
        end
        default: begin
          tx_st_d   = TX_IDLE;
          tx_line_d = 1'b1;
        end
      endcase
    end
  end

  // received character; 8-bit data sits in shift bits 8 to 1
  always_comb begin
    rx_word = nine ? rx_sh_q : {1'b0, rx_sh_q[8:1]};
  end

  // receiver next state and idle counting
  always_comb begin
    rx_st_d   = rx_st_q;
    rx_cnt_d  = rx_cnt_q;
    rx_bit_d  = rx_bit_q;
    rx_sh_d   = rx_sh_q;
    run1_d    = run1_q;
    armed_d   = armed_q;
    rx_prev_d = run ? rx_in : rx_prev_q;
    got_char  = 1'b0;
    idle_hit  = 1'b0;
    if (run && rx_on) begin
      case (rx_st_q)
        RX_IDLE: begin
          if (rx_prev_q && !rx_in) begin
            rx_st_d  = RX_START;
            rx_cnt_d = '0;
          end else if (rx_in) begin
            // one more high bit time toward an idle line
            rx_cnt_d = rx_cnt_q + 1'b1;
            if (rx_cnt_q == BIT_LAST) begin
              rx_cnt_d = '0;
              if (run1_q != idle_goal) begin
                run1_d = run1_q + 1'b1;
              end
            end
            if (armed_q && run1_q == idle_goal) begin
              idle_hit = 1'b1;
              armed_d  = 1'b0;
            end
          end
        end
        RX_START: begin
          rx_cnt_d = rx_cnt_q + 1'b1;
          if (rx_cnt_q == HALF_LAST) begin
            rx_cnt_d = '0;
            rx_bit_d = '0;
            run1_d   = '0;
            rx_st_d  = rx_in ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          rx_cnt_d = rx_cnt_q + 1'b1;
          if (rx_cnt_q == BIT_LAST) begin
            rx_cnt_d = '0;
            rx_sh_d  = {rx_in, rx_sh_q[8:1]};
            run1_d   = rx_in ? run1_q + 1'b1 : '0;
            rx_bit_d = rx_bit_q + 1'b1;
            if (rx_bit_q == last_bit) begin
              rx_st_d = RX_STOP;
            end
          end
        end
        RX_STOP: begin
          rx_cnt_d = rx_cnt_q + 1'b1;
          if (rx_cnt_q == BIT_LAST) begin
            got_char = 1'b1;
            armed_d  = 1'b1;
            rx_cnt_d = '0;
            rx_st_d  = RX_IDLE;
            if (fmt_q[`FMT_IDLE_TYPE]) begin
              run1_d = '0;
            end else if (rx_in) begin
              run1_d = run1_q + 1'b1;
            end else begin
              run1_d = '0;
            end
          end
        end
        default: begin
          rx_st_d = RX_IDLE;
        end
      endcase
    end
  end

  // register writes, flags, wakeup and pin routing
  always_comb begin
    fmt_d   = fmt_q;
    en_d    = en_q;
    dir_d   = dir_q;
    txbuf_d = txbuf_q;
    rxbuf_d = rxbuf_q;
    txe_d   = txe_q;
    txc_d   = txc_q;
    rxf_d   = rxf_q;
    idle_d  = idle_q;
    fe_d    = fe_q;
    perr_d  = perr_q;
    // wakeup: idle line, or a set msb in address-mark mode
    wake_clear = en_q[`EN_STANDBY] &&
                 (fmt_q[`FMT_WAKE] ? (got_char && (nine ? rx_word[8] : rx_word[7]))
                                   : idle_hit);
    if (wake_clear) begin
      en_d[`EN_STANDBY] = 1'b0;
    end
    if (wr && hit_fmt) begin
      fmt_d = pwdata[7:0];
    end
    if (wr && hit_en) begin
      en_d = pwdata[7:0];
    end
    if (wr && hit_dir) begin
      dir_d = pwdata[`DIR_OUT];
    end
    if (wr && hit_data) begin
      txbuf_d = pwdata[8:0];
      txe_d   = 1'b0;
      txc_d   = 1'b0;
    end
    if (rd && hit_data) begin
      rxf_d  = 1'b0;
      idle_d = 1'b0;
      fe_d   = 1'b0;
      perr_d = 1'b0;
    end
    // hardware sets come last so they win over a clear
    if (load) begin
      txe_d = 1'b1;
    end
    if (frame_end && txe_q) begin
      txc_d = 1'b1;
    end
    if (idle_hit && !en_q[`EN_STANDBY]) begin
      idle_d = 1'b1;
    end
    if (got_char && (!en_q[`EN_STANDBY] || wake_clear)) begin
      rxbuf_d = rx_word;
      rxf_d   = 1'b1;
      fe_d    = ~rx_in;
      perr_d  = fmt_q[`FMT_PAR] & ((^rx_word) != fmt_q[`FMT_ODD]);
    end
    // pin ownership and drive
    own_d = (tx_on | (tx_st_q != TX_IDLE)) & ~internal;
    oe_d  = own_d & (~single | dir_q);
    // interrupt requests hold while frozen
    frz_d  = ~run;
    tirq_d = run ? (txe_q & en_q[`EN_TXE_IRQ]) : tirq_q;
    cirq_d = run ? (txc_q & ~en_q[`EN_TXDONE_IRQ]) : cirq_q;
  end

  // pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_meta_q <= 1'b1;
      rxd_sync_q <= 1'b1;
      txi_meta_q <= 1'b1;
      txi_sync_q <= 1'b1;
    end else begin
      rxd_meta_q <= rxd_pin;
      rxd_sync_q <= rxd_meta_q;
      txi_meta_q <= txd_pin_in;
      txi_sync_q <= txi_meta_q;
    end
  end

  // all state registers except the pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= '0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      fmt_q     <= `FORMAT_RST;
      en_q      <= `ENABLE_RST;
      dir_q     <= `DIR_RST;
      txbuf_q   <= '0;
      rxbuf_q   <= '0;
      txe_q     <= 1'b1;
      txc_q     <= 1'b1;
      rxf_q     <= 1'b0;
      idle_q    <= 1'b0;
      fe_q      <= 1'b0;
      perr_q    <= 1'b0;
      oe_q      <= 1'b0;
      own_q     <= 1'b0;
      tirq_q    <= 1'b0;
      cirq_q    <= 1'b0;
      frz_q     <= 1'b0;
      tx_st_q   <= TX_IDLE;
      tx_cnt_q  <= '0;
      tx_bit_q  <= '0;
      tx_sh_q   <= '0;
      tx_line_q <= 1'b1;
      rx_st_q   <= RX_IDLE;
      rx_cnt_q  <= '0;
      rx_bit_q  <= '0;
      rx_sh_q   <= '0;
      rx_prev_q <= 1'b1;
      run1_q    <= '0;
      armed_q   <= 1'b0;
    end else begin
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      fmt_q     <= fmt_d;
      en_q      <= en_d;
      dir_q     <= dir_d;
      txbuf_q   <= txbuf_d;
      rxbuf_q   <= rxbuf_d;
      txe_q     <= txe_d;
      txc_q     <= txc_d;
      rxf_q     <= rxf_d;
      idle_q    <= idle_d;
      fe_q      <= fe_d;
      perr_q    <= perr_d;
      oe_q      <= oe_d;
      own_q     <= own_d;
      tirq_q    <= tirq_d;
      cirq_q    <= cirq_d;
      frz_q     <= frz_d;
      tx_st_q   <= tx_st_d;
      tx_cnt_q  <= tx_cnt_d;
      tx_bit_q  <= tx_bit_d;
      tx_sh_q   <= tx_sh_d;
      tx_line_q <= tx_line_d;
      rx_st_q   <= rx_st_d;
      rx_cnt_q  <= rx_cnt_d;
      rx_bit_q  <= rx_bit_d;
      rx_sh_q   <= rx_sh_d;
      rx_prev_q <= rx_prev_d;
      run1_q    <= run1_d;
      armed_q   <= armed_d;
    end
  end

  // outputs straight from flip-flops
  assign prdata        = prdata_q;
  assign pready        = pready_q;
  assign pslverr       = pslverr_q;
  assign txd_pin_out   = tx_line_q;
  assign txd_pin_oe    = oe_q;
  assign txd_pin_owned = own_q;
  assign tx_empty_irq  = tirq_q;
  assign tx_done_irq   = cirq_q;
  assign clocks_frozen = frz_q;
endmodule

//--- testbench/uart_remote_node.sv
// remote serial node: sends and captures frames at 16 clocks per bit
`timescale 1ns/10ps
module uart_remote_node (
  input  wire logic pclk,     // bus clock, also paces bit times
  input  wire logic line_in,  // line driven by the block
  output logic      line_out  // line towards the block, idles high
);
  initial line_out = 1'b1;
  // start bit, n data bits lsb first, then stop bit
  task automatic send(input int n, input logic [8:0] d);
    @(posedge pclk);
    line_out <= 1'b0;
    repeat (16) @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      line_out <= d[i];
      repeat (16) @(posedge pclk);
    end
    line_out <= 1'b1;
    repeat (16) @(posedge pclk);
  endtask
  // capture one frame mid-bit; the stop bit lands just above the data
  task automatic get(input int n, output logic [9:0] v);
    v = '0;
    @(negedge line_in);
    repeat (8) @(posedge pclk);
    for (int i = 0; i <= n; i++) begin
      repeat (16) @(posedge pclk);
      v[i] = line_in;
    end
  endtask
endmodule

//--- testbench/uart_frame_and_loop_control_sva.sv
// checker: bus timing, pin routing, freeze and interrupt gating
`timescale 1ns/10ps
`include "uart_frame_defs.svh"
module uart_frame_and_loop_control_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        cpu_wait,
  input wire logic        txd_pin_out,
  input wire logic        txd_pin_oe,
  input wire logic        txd_pin_owned,
  input wire logic        tx_empty_irq,
  input wire logic        tx_done_irq,
  input wire logic        clocks_frozen
);
  logic [7:0] fmt_q;  // shadow of the format register
  logic [7:0] en_q;   // shadow of the enable register
  logic       dir_q;  // shadow of the direction bit
  logic       wr_acc; // write completing at this edge
  assign wr_acc = psel && penable && pready && pwrite;
  // shadows follow completed writes so gating can be predicted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fmt_q <= 8'h00;
      en_q  <= 8'h00;
      dir_q <= 1'b0;
    end else if (wr_acc) begin
      if (paddr == `OFS_FORMAT) fmt_q <= pwdata[7:0];
      if (paddr == `OFS_ENABLE) en_q <= pwdata[7:0];
      if (paddr == `OFS_DIR) dir_q <= pwdata[0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_unmapped_error: assert property (psel && !penable && paddr > `OFS_DIR
    |=> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
  a_freeze_on_wait: assert property (cpu_wait && fmt_q[6] |=> clocks_frozen)
    else $error("block not frozen in wait");
  a_run_in_wait: assert property (!(cpu_wait && fmt_q[6]) |=> !clocks_frozen)
    else $error("block frozen without cause");
  a_loop_pin_free: assert property (fmt_q[7] && !fmt_q[5] && $stable(fmt_q)
    |=> !txd_pin_oe && !txd_pin_owned) else $error("pin kept in loop-back");
  a_wire_direction: assert property (fmt_q[7] && fmt_q[5] && $stable(fmt_q) && $stable(dir_q)
    |=> txd_pin_oe == (txd_pin_owned && $past(dir_q))) else $error("single wire drive wrong");
  a_empty_irq_gate: assert property (!cpu_wait && !clocks_frozen && !en_q[7]
    |=> !tx_empty_irq) else $error("empty request while disabled");
  a_done_irq_gate: assert property (!cpu_wait && !clocks_frozen && en_q[6]
    |=> !tx_done_irq) else $error("done request while disabled");
  a_line_idle_reset: assert property (!$past(presetn) |-> txd_pin_out)
    else $error("serial line not idle after reset");
endmodule
bind uart_frame_and_loop_control uart_frame_and_loop_control_sva uart_frame_and_loop_control_sva_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cpu_wait(cpu_wait), .txd_pin_out(txd_pin_out), .txd_pin_oe(txd_pin_oe),
  .txd_pin_owned(txd_pin_owned), .tx_empty_irq(tx_empty_irq), .tx_done_irq(tx_done_irq),
  .clocks_frozen(clocks_frozen));

//--- testbench/uart_frame_and_loop_control_bench.sv
// self-checking bench of the serial control block
`timescale 1ns/10ps
`include "uart_frame_defs.svh"
module uart_frame_and_loop_control_bench;
  logic        pclk = 1'b0;                       // bus clock
  logic        presetn, psel, penable, pwrite, cpu_wait, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        pready, pslverr, txd_pin_out, txd_pin_oe, txd_pin_owned;
  logic        tx_empty_irq, tx_done_irq, clocks_frozen, rxd_line, txd_wire;
  logic [9:0]  cap;                               // captured frame
  logic [7:0]  fmts [5] = '{8'h00, 8'h02, 8'h03, 8'h10, 8'h12};
  logic [8:0]  dats [5] = '{9'h0A5, 9'h0B5, 9'h035, 9'h1A5, 9'h1FF};
  logic [9:0]  exps [5] = '{10'h1A5, 10'h135, 10'h1B5, 10'h3A5, 10'h2FF};
  int          fails = 0;
  int          checks_done = 0;
  // released transmit pin follows the remote node's line
  assign txd_wire = txd_pin_oe ? txd_pin_out : rxd_line;
  // 100 MHz clock
  always #5 pclk = ~pclk;
  uart_frame_and_loop_control uart_frame_and_loop_control_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_wait(cpu_wait), .rxd_pin(rxd_line), .txd_pin_in(txd_wire),
    .txd_pin_out(txd_pin_out), .txd_pin_oe(txd_pin_oe), .txd_pin_owned(txd_pin_owned),
    .tx_empty_irq(tx_empty_irq), .tx_done_irq(tx_done_irq), .clocks_frozen(clocks_frozen));
  uart_remote_node uart_remote_node_i (.pclk(pclk), .line_in(txd_wire), .line_out(rxd_line));
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // one apb transfer: setup, then access until ready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fails++;
    rdat = prdata;
    er   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rdat, exp);
  endtask
  // summary, verdict and end of run
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // watchdog cuts a hang short
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    give_verdict;
  end
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, cpu_wait} = 5'h00;
    paddr  = 12'h000;
    pwdata = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(`OFS_FORMAT, 32'h0);
    rdchk(`OFS_ENABLE, 32'h0);
    check(tx_done_irq, 1'b1);
    check(tx_empty_irq, 1'b0);
    wr(`OFS_FORMAT, 32'h1FF);
    rdchk(`OFS_FORMAT, 32'hFF);
    wr(`OFS_ENABLE, 32'hC6);
    rdchk(`OFS_ENABLE, 32'hC6);
    apb(1'b0, 12'h020, 32'h0);
    check(er, 1'b1);
    check(rdat, 32'h0);
    // freeze follows the wait-stop bit only
    wr(`OFS_FORMAT, 32'h40);
    cpu_wait <= 1'b1;
    repeat (3) @(posedge pclk);
    check(clocks_frozen, 1'b1);
    wr(`OFS_FORMAT, 32'h00);
    repeat (3) @(posedge pclk);
    check(clocks_frozen, 1'b0);
    cpu_wait <= 1'b0;
    // transmit each format; parity replaces the top data bit
    wr(`OFS_ENABLE, 32'h88);
    for (int k = 0; k < 5; k++) begin
      wr(`OFS_FORMAT, {24'h0, fmts[k]});
      fork
        uart_remote_node_i.get(fmts[k][4] ? 9 : 8, cap);
        wr(`OFS_DATA, {23'h0, dats[k]});
      join
      check(cap, exps[k]);
      repeat (24) @(posedge pclk);
      check(tx_empty_irq, 1'b1);
      check(tx_done_irq, 1'b1);
    end
    wr(`OFS_ENABLE, 32'h48);
    repeat (3) @(posedge pclk);
    check(tx_done_irq, 1'b0);
    wr(`OFS_ENABLE, 32'h08);
    repeat (3) @(posedge pclk);
    check(tx_empty_irq, 1'b0);
    check(tx_done_irq, 1'b1);
    // normal receive from the pin, source bit ignored
    wr(`OFS_FORMAT, 32'h20);
    wr(`OFS_ENABLE, 32'h0C);
    uart_remote_node_i.send(8, 9'h03C);
    repeat (20) @(posedge pclk);
    rdchk(`OFS_DATA, 32'h3C);
    // idle flag once ten high bit times follow the character
    repeat (150) @(posedge pclk);
    rdchk(`OFS_STATUS, 32'hD0);
    // address-mark wakeup: only a character with its msb set is kept
    wr(`OFS_FORMAT, 32'h08);
    wr(`OFS_ENABLE, 32'h0E);
    uart_remote_node_i.send(8, 9'h011);
    uart_remote_node_i.send(8, 9'h0A1);
    repeat (20) @(posedge pclk);
    rdchk(`OFS_ENABLE, 32'h0C);
    rdchk(`OFS_DATA, 32'hA1);
    // loop-back ignores the receive pin and frees the transmit pin
    wr(`OFS_FORMAT, 32'h80);
    fork
      uart_remote_node_i.send(8, 9'h0FF);
      wr(`OFS_DATA, 32'h5A);
    join
    repeat (60) @(posedge pclk);
    rdchk(`OFS_DATA, 32'h5A);
    check(txd_pin_owned, 1'b0);
    check(txd_pin_oe, 1'b0);
    // single wire: direction bit steers the shared pin
    wr(`OFS_FORMAT, 32'hA0);
    wr(`OFS_DIR, 32'h1);
    repeat (3) @(posedge pclk);
    check(txd_pin_oe, 1'b1);
    wr(`OFS_DIR, 32'h0);
    repeat (3) @(posedge pclk);
    check(txd_pin_oe, 1'b0);
    uart_remote_node_i.send(8, 9'h096);
    repeat (20) @(posedge pclk);
    rdchk(`OFS_DATA, 32'h96);
    give_verdict;
  end
endmodule
